// ---- rtl/asp_pkg.sv ----
// constants and types shared by the audio serial framing and clock block
package asp_pkg;
   // register bus geometry
   localparam int ASP_AW = 12;
   localparam logic [ASP_AW-1:0] ASP_OFS_CTRL = 12'h000; // framing and mode control
   localparam logic [ASP_AW-1:0] ASP_OFS_PSC = 12'h004; // clock generator settings
   localparam logic [ASP_AW-1:0] ASP_OFS_DATA = 12'h008; // half-word data port
   localparam logic [ASP_AW-1:0] ASP_OFS_STAT = 12'h00C; // state and sticky flags
   // control register fields
   localparam int ASP_CTL_EN = 0;
   localparam int ASP_CTL_FMT = 1; // two bits
   localparam int ASP_CTL_MODE = 3; // two bits
   localparam int ASP_CTL_SWID = 5; // two bits
   localparam int ASP_CTL_SLOT = 7;
   localparam int ASP_CTL_POL = 8;
   localparam int ASP_CTL_LSYNC = 9;
   localparam logic [31:0] ASP_CTL_MASK = 32'h0000_03FF;
   localparam logic [31:0] ASP_CTL_RST = 32'h0000_0000;
   // prescaler register fields
   localparam int ASP_PSC_DIV = 0; // eight bits
   localparam int ASP_PSC_ODD = 8;
   localparam int ASP_PSC_MCKEN = 9;
   localparam logic [31:0] ASP_PSC_MASK = 32'h0000_03FF;
   localparam logic [31:0] ASP_PSC_RST = 32'h0000_0002;
   // status register fields
   localparam int ASP_ST_TXE = 0;
   localparam int ASP_ST_RXNE = 1;
   localparam int ASP_ST_CHAN = 2;
   localparam int ASP_ST_URUN = 3;
   localparam int ASP_ST_ORUN = 4;
   localparam int ASP_ST_BUSY = 5;
   // framing constants
   localparam logic [4:0] ASP_LAST16 = 5'd15;
   localparam logic [4:0] ASP_LAST32 = 5'd31;
   localparam logic [4:0] ASP_LONG_SYNC_BITS = 5'd13;
   localparam logic [8:0] ASP_MIN_DIV = 9'd2;
   typedef enum logic [1:0] {
      ASP_FMT_PHIL = 2'b00,
      ASP_FMT_MSB = 2'b01,
      ASP_FMT_LSB = 2'b10,
      ASP_FMT_PCM = 2'b11
   } asp_fmt_e;
   typedef enum logic [1:0] {
      ASP_MODE_MTX = 2'b00,
      ASP_MODE_MRX = 2'b01,
      ASP_MODE_STX = 2'b10,
      ASP_MODE_SRX = 2'b11
   } asp_mode_e;
   typedef enum logic [1:0] {
      ASP_WID_16 = 2'b00,
      ASP_WID_24 = 2'b01,
      ASP_WID_32 = 2'b10,
      ASP_WID_RSV = 2'b11
   } asp_wid_e;
endpackage : asp_pkg

// ---- rtl/asp_core.sv ----
// audio serial framing engine with bit and master clock generator and apb slave
//
// Notes on behaviour
// (R1) lsb-justified: ws and data change on falling edge
// (R2) equal lengths: lsb framing equals msb framing
// (R3) lsb aligns low in slot, msb high
// (R4) software writes low-byte d23..16 first, then d15..0
// (R5) rx lsb 24-bit: zero-padded d23..16, then d15..0
// (R6) 24-bit in 32 slot: two half-words
// (R7) 16-bit in 32 slot: one access, zero fill
// (R8) pcm: rising edge update, ws is frame sync
// (R9) pcm: bit selects short or long sync
// (R10) pcm packs half-words like phillips
// (R11) software writes d23..8 then d7..0 high byte
// (R12) msb first, left channel before right
// (R13) generator from system clock, divider and bits
// (R14) no mclk: bit rate clk/(2div+odd)
// (R15) mclk: divide by 8 or 4 times
// (R16) sample rate is bitrate over two slots of bits
// (R17) mclk: sample rate clk/(256(2div+odd))
// (R18) no mclk: sample rate over 32 or 64
// (R19) two-bit field picks one of four modes
// (R20) master drives clock, ws, optional mclk
// (R21) slave takes clock and ws as inputs
// (R22) unused mclk pin is released
// (R23) width codes 00/01/10, slot bit 0/1
// (R24) short sync one bit, long thirteen bits
// (R25) polarity sets idle level, flips edges
//
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
module asp_core (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [asp_pkg::ASP_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic bclk_in,
   output logic bclk_out,
   output logic bclk_oe,
   input wire logic ws_in,
   output logic ws_out,
   output logic ws_oe,
   input wire logic sd_in,
   output logic sd_out,
   output logic sd_oe,
   output logic mclk_out,
   output logic mclk_oe
);
   import asp_pkg::*;

   logic [31:0] ctrl_ff, psc_ff; // software settings
   logic pready_ff, pslverr_ff; // bus answer
   logic [31:0] prdata_ff;
   logic pop_arm_ff; // read captured a valid half-word
   logic [15:0] tx_half_ff; // first half of a two-part sample
   logic tx_have_ff; // first half held
   logic [31:0] tx_word_ff; // slot word, left aligned
   logic tx_vld_ff; // slot word waiting for the shifter
   logic [31:0] tx_sr_ff; // transmit shifter, current bit at top
   logic [30:0] rx_sr_ff; // receive shifter
   logic [15:0] rx_a_ff, rx_b_ff; // received half-words, a read first
   logic [1:0] rx_n_ff; // half-words held
   logic urun_ff, orun_ff; // sticky error flags
   logic chan_flag_ff; // side of last loaded or received word
   logic started_ff; // transfer running
   logic [11:0] bcnt_ff; // bit period counter
   logic [8:0] mcnt_ff; // master clock period counter
   logic ph_prev_ff; // previous internal clock phase
   logic ws_prev_ff; // ws seen at previous sample edge
   logic [4:0] pos_ff; // bit index inside the slot
   logic chan_ff; // 0 left, 1 right
   logic bclk_ff, bclk_oe_ff, ws_ff, ws_oe_ff, sd_ff, sd_oe_ff, mclk_ff, mclk_oe_ff;

   // decoded settings
   logic en, slot32, pol, lsync, mcken, odd, is_master, is_tx;
   asp_fmt_e fmt;
   asp_wid_e swid;
   asp_mode_e mode;
   logic [7:0] div;
   assign en = ctrl_ff[ASP_CTL_EN];
   assign fmt = asp_fmt_e'(ctrl_ff[ASP_CTL_FMT +: 2]);
   assign mode = asp_mode_e'(ctrl_ff[ASP_CTL_MODE +: 2]); // see (R19)
   assign swid = asp_wid_e'(ctrl_ff[ASP_CTL_SWID +: 2]); // see (R23)
   // a slot never shorter than the sample: wide samples force 32-bit slots
   assign slot32 = ctrl_ff[ASP_CTL_SLOT] | (swid != ASP_WID_16); // see (R23)
   assign pol = ctrl_ff[ASP_CTL_POL];
   assign lsync = ctrl_ff[ASP_CTL_LSYNC];
   assign div = psc_ff[ASP_PSC_DIV +: 8];
   assign odd = psc_ff[ASP_PSC_ODD];
   assign mcken = psc_ff[ASP_PSC_MCKEN];
   assign is_master = (mode == ASP_MODE_MTX) || (mode == ASP_MODE_MRX);
   assign is_tx = (mode == ASP_MODE_MTX) || (mode == ASP_MODE_STX);

   // bus decode; answer comes one cycle into the access phase
   logic acc, done, hit, rd_data, wr_data, rd_stat;
   assign acc = psel & penable;
   assign done = acc & pready_ff;
   assign hit = (paddr == ASP_OFS_CTRL) || (paddr == ASP_OFS_PSC) ||
                (paddr == ASP_OFS_DATA) || (paddr == ASP_OFS_STAT);
   assign rd_data = done & ~pwrite & (paddr == ASP_OFS_DATA);
   assign wr_data = done & pwrite & (paddr == ASP_OFS_DATA);
   assign rd_stat = done & ~pwrite & (paddr == ASP_OFS_STAT);

   // clock generator: period in system cycles
   logic [8:0] ndiv, ndiv_raw;
   logic [11:0] per, nxt_bcnt;
   logic m_ph, run;
   always_comb begin
      ndiv_raw = {div, 1'b0} + {8'h00, odd}; // see (R13)
      ndiv = (ndiv_raw < ASP_MIN_DIV) ? ASP_MIN_DIV : ndiv_raw; // zero or one cannot toggle
      if (!mcken) begin
         per = {3'b000, ndiv}; // see (R14)
      end else if (slot32) begin
         per = {1'b0, ndiv, 2'b00}; // see (R15)
      end else begin
         per = {ndiv, 3'b000}; // see (R15)
      end
      nxt_bcnt = (bcnt_ff >= per - 12'd1) ? 12'd0 : bcnt_ff + 12'd1;
      m_ph = (bcnt_ff >= {1'b0, per[11:1]}); // low half first, then high half
   end
   // master runs only once started; slaves follow the pin at once
   assign run = en & is_master & started_ff; // see (R20)

   // internal phase and edges; polarity only flips the pin, so edges flip too
   logic cur_ph, rise, fall, upd, smp;
   always_comb begin
      cur_ph = is_master ? m_ph : (bclk_in ^ pol); // see (R21) (R25)
      rise = en & cur_ph & ~ph_prev_ff;
      fall = en & ~cur_ph & ph_prev_ff;
      upd = (fmt == ASP_FMT_PCM) ? rise : fall; // see (R1) (R8)
      smp = (fmt == ASP_FMT_PCM) ? fall : rise;
   end

   // slot position stepping and slave resynchronisation from ws
   logic [4:0] last, adv_pos, spos, eff_pos;
   logic adv_chan, sync, schan, adv_wrap;
   always_comb begin
      last = slot32 ? ASP_LAST32 : ASP_LAST16;
      adv_wrap = (pos_ff >= last);
      adv_pos = adv_wrap ? 5'd0 : pos_ff + 5'd1;
      // pcm carries one channel per frame, others alternate left then right
      adv_chan = adv_wrap ? ((fmt == ASP_FMT_PCM) ? 1'b0 : ~chan_ff) : chan_ff; // see (R12)
      sync = 1'b0;
      spos = 5'd0;
      schan = ws_in;
      case (fmt)
         ASP_FMT_PHIL: begin // ws leads data by one bit
            sync = (ws_in != ws_prev_ff);
            spos = last;
            schan = ~ws_in;
         end
         ASP_FMT_MSB, ASP_FMT_LSB: begin // ws changes with first bit
            sync = (ws_in != ws_prev_ff);
         end
         ASP_FMT_PCM: begin
            schan = 1'b0;
            if (lsync) begin // long pulse: rising ws marks bit 0
               sync = ws_in & ~ws_prev_ff;
            end else begin // short pulse: bit before bit 0
               sync = ws_in;
               spos = last;
            end
         end
         default: begin
            sync = 1'b0;
         end
      endcase
      sync = sync & smp & ~is_master;
      eff_pos = sync ? spos : pos_ff;
   end

   // master ws shape, computed for the bit that starts at this update
   logic nxt_ws;
   always_comb begin
      case (fmt)
         ASP_FMT_PHIL: nxt_ws = (adv_pos == last) ? ~adv_chan : adv_chan;
         ASP_FMT_MSB, ASP_FMT_LSB: nxt_ws = adv_chan;
         ASP_FMT_PCM: nxt_ws = lsync ? (adv_pos < ASP_LONG_SYNC_BITS) : (adv_pos == last); // see (R9) (R24)
         default: nxt_ws = 1'b0;
      endcase
   end

   // half-words into a left aligned slot word; h1 first write, h2 last
   function automatic logic [31:0] tx_compose(input logic lsb, input logic s32, input asp_wid_e w,
                                              input logic [15:0] h1, input logic [15:0] h2);
      logic [31:0] r;
      r = {h1, h2}; // 32-bit sample, also r2 for equal lengths
      case (w)
         ASP_WID_16: r = (lsb && s32) ? {16'h0000, h2} : {h2, 16'h0000}; // see (R2) (R3) (R7)
         ASP_WID_24: r = lsb ? {8'h00, h1[7:0], h2} : {h1, h2[15:8], 8'h00}; // see (R3) (R4) (R10) (R11)
         default: r = {h1, h2};
      endcase
      return r;
   endfunction : tx_compose

   // received slot split into presented half-words
   logic [31:0] rx_raw, rx_l;
   logic [15:0] rx_h1, rx_h2;
   logic [1:0] rx_cnt;
   logic lsb_fmt, need_two;
   always_comb begin
      lsb_fmt = (fmt == ASP_FMT_LSB);
      need_two = (swid != ASP_WID_16); // see (R6)
      rx_raw = {rx_sr_ff, sd_in};
      rx_l = slot32 ? rx_raw : {rx_raw[15:0], 16'h0000};
      rx_h1 = rx_l[31:16];
      rx_h2 = rx_l[15:0];
      rx_cnt = 2'd2;
      case (swid)
         ASP_WID_16: begin
            rx_h1 = (lsb_fmt && slot32) ? rx_l[15:0] : rx_l[31:16]; // see (R3) (R7)
            rx_cnt = 2'd1;
         end
         ASP_WID_24: begin
            if (lsb_fmt) begin
               rx_h1 = {8'h00, rx_l[23:16]}; // see (R5)
               rx_h2 = rx_l[15:0];
            end else begin
               rx_h2 = {rx_l[15:8], 8'h00}; // see (R10)
            end
         end
         default: rx_cnt = 2'd2;
      endcase
   end

   // shifter events
   logic load, push, pop, rx_free;
   assign load = upd & is_tx & (adv_pos == 5'd0) & (is_master ? run : started_ff);
   assign push = smp & ~is_tx & started_ff & (eff_pos == last);
   assign pop = rd_data & pop_arm_ff;
   assign rx_free = ((rx_n_ff - {1'b0, pop}) == 2'd0);

   // apb answer and read mux
   always_ff @(posedge clk) begin
      if (rst) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h0000_0000;
         pop_arm_ff <= 1'b0;
      end else begin
         pready_ff <= acc & ~pready_ff;
         pslverr_ff <= acc & ~pready_ff & ~hit; // unmapped: error, reads zero
         pop_arm_ff <= acc & ~pready_ff & ~pwrite & (paddr == ASP_OFS_DATA) & (rx_n_ff != 2'd0);
         prdata_ff <= 32'h0000_0000;
         if (acc && !pready_ff && !pwrite) begin
            case (paddr)
               ASP_OFS_CTRL: prdata_ff <= ctrl_ff;
               ASP_OFS_PSC: prdata_ff <= psc_ff;
               ASP_OFS_DATA: prdata_ff <= {16'h0000, (rx_n_ff != 2'd0) ? rx_a_ff : 16'h0000};
               ASP_OFS_STAT: prdata_ff <= {26'h000_0000, started_ff, orun_ff, urun_ff, chan_flag_ff,
                                           (rx_n_ff != 2'd0), ~tx_vld_ff};
               default: prdata_ff <= 32'h0000_0000;
            endcase
         end
      end
   end

   // settings registers
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_ff <= ASP_CTL_RST;
         psc_ff <= ASP_PSC_RST;
      end else if (done && pwrite) begin
         if (paddr == ASP_OFS_CTRL) begin
            ctrl_ff <= pwdata & ASP_CTL_MASK;
         end
         if (paddr == ASP_OFS_PSC) begin
            psc_ff <= pwdata & ASP_PSC_MASK;
         end
      end
   end

   // transmit assembly: writes ignored while a slot word is waiting
   always_ff @(posedge clk) begin
      if (rst) begin
         tx_half_ff <= 16'h0000;
         tx_have_ff <= 1'b0;
         tx_word_ff <= 32'h0000_0000;
         tx_vld_ff <= 1'b0;
      end else if (wr_data && !tx_vld_ff) begin
         if (need_two && !tx_have_ff) begin
            tx_half_ff <= pwdata[15:0]; // see (R6)
            tx_have_ff <= 1'b1;
         end else begin
            tx_word_ff <= tx_compose(lsb_fmt, slot32, swid, tx_half_ff, pwdata[15:0]);
            tx_vld_ff <= 1'b1;
            tx_have_ff <= 1'b0;
         end
      end else if (load) begin
         tx_vld_ff <= 1'b0;
      end
   end

   // receive holding: one sample, read as one or two half-words
   always_ff @(posedge clk) begin
      if (rst) begin
         rx_a_ff <= 16'h0000;
         rx_b_ff <= 16'h0000;
         rx_n_ff <= 2'd0;
      end else if (push && rx_free) begin
         rx_a_ff <= rx_h1; // see (R5) (R6)
         rx_b_ff <= rx_h2;
         rx_n_ff <= rx_cnt;
      end else if (pop) begin
         rx_a_ff <= rx_b_ff;
         rx_n_ff <= rx_n_ff - 2'd1;
      end
   end

   // sticky errors: a status read clears, a same-cycle event wins
   always_ff @(posedge clk) begin
      if (rst) begin
         urun_ff <= 1'b0;
         orun_ff <= 1'b0;
      end else begin
         urun_ff <= (load & ~tx_vld_ff & ~is_master) | (urun_ff & ~rd_stat);
         orun_ff <= (push & ~rx_free) | (orun_ff & ~rd_stat);
      end
   end

   // start condition and channel side flag
   always_ff @(posedge clk) begin
      if (rst) begin
         started_ff <= 1'b0;
         chan_flag_ff <= 1'b0;
      end else begin
         if (!en) begin
            started_ff <= 1'b0;
         end else if (is_master ? (!is_tx || tx_vld_ff) : sync) begin
            started_ff <= 1'b1; // master rx starts at enable, tx on first word
         end
         if (load || (push && rx_free)) begin
            chan_flag_ff <= load ? adv_chan : chan_ff;
         end
      end
   end

   // dividers; both restart together so mclk stays aligned with the bit clock
   always_ff @(posedge clk) begin
      if (rst || !run) begin
         bcnt_ff <= 12'd0;
         mcnt_ff <= 9'd0;
      end else begin
         bcnt_ff <= nxt_bcnt;
         mcnt_ff <= (mcnt_ff >= ndiv - 9'd1) ? 9'd0 : mcnt_ff + 9'd1;
      end
   end

   // phase history and slave ws history
   always_ff @(posedge clk) begin
      if (rst) begin
         ph_prev_ff <= 1'b0;
         ws_prev_ff <= 1'b0;
      end else begin
         ph_prev_ff <= cur_ph;
         if (smp) begin
            ws_prev_ff <= ws_in;
         end
      end
   end

   // slot position: steps on update edges, slaves realign on sample edges
   always_ff @(posedge clk) begin
      if (rst || !en) begin
         pos_ff <= ASP_LAST32; // first step lands on bit 0 of the left side
         chan_ff <= 1'b1;
      end else if (upd) begin
         pos_ff <= adv_pos; // see (R16) (R18)
         chan_ff <= adv_chan; // see (R12)
      end else if (sync) begin
         pos_ff <= spos; // see (R21)
         chan_ff <= schan;
      end
   end

   // shifters, msb first
   always_ff @(posedge clk) begin
      if (rst) begin
         tx_sr_ff <= 32'h0000_0000;
         rx_sr_ff <= 31'h0000_0000;
      end else begin
         if (load) begin
            tx_sr_ff <= tx_vld_ff ? tx_word_ff : 32'h0000_0000; // underrun sends silence
         end else if (upd) begin
            tx_sr_ff <= {tx_sr_ff[30:0], 1'b0}; // see (R12)
         end
         if (smp) begin
            rx_sr_ff <= rx_raw[30:0];
         end
      end
   end

   // pins; clock idles at the polarity level
   always_ff @(posedge clk) begin
      if (rst) begin
         bclk_ff <= 1'b0;
         ws_ff <= 1'b0;
         sd_ff <= 1'b0;
         mclk_ff <= 1'b0;
      end else begin
         bclk_ff <= cur_ph ^ pol; // see (R25)
         if (upd && run) begin
            ws_ff <= nxt_ws; // see (R1) (R8)
         end else if (!run) begin
            ws_ff <= 1'b0;
         end
         if (load) begin
            sd_ff <= tx_vld_ff & tx_word_ff[31];
         end else if (upd) begin
            sd_ff <= tx_sr_ff[30];
         end
         mclk_ff <= run & mcken & (mcnt_ff >= {1'b0, ndiv[8:1]}); // see (R17)
      end
   end

   // pin direction per operating mode
   always_ff @(posedge clk) begin
      if (rst) begin
         bclk_oe_ff <= 1'b0;
         ws_oe_ff <= 1'b0;
         sd_oe_ff <= 1'b0;
         mclk_oe_ff <= 1'b0;
      end else begin
         bclk_oe_ff <= en & is_master; // see (R20) (R21)
         ws_oe_ff <= en & is_master;
         sd_oe_ff <= en & is_tx;
         mclk_oe_ff <= en & is_master & mcken; // see (R22)
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign bclk_out = bclk_ff;
   assign bclk_oe = bclk_oe_ff;
   assign ws_out = ws_ff;
   assign ws_oe = ws_oe_ff;
   assign sd_out = sd_ff;
   assign sd_oe = sd_oe_ff;
   assign mclk_out = mclk_ff;
   assign mclk_oe = mclk_oe_ff;
endmodule : asp_core

// ---- sim/asp_core_asserts.sv ----
// port assertions for the audio serial framing block
`timescale 1ns/1ns
module asp_core_asserts (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [asp_pkg::ASP_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic bclk_out,
   input wire logic bclk_oe,
   input wire logic ws_out,
   input wire logic ws_oe,
   input wire logic sd_out,
   input wire logic sd_oe,
   input wire logic mclk_oe
);
   import asp_pkg::*;
   logic [31:0] ctl_ff; // control shadow
   logic [31:0] psc_ff; // prescaler shadow
   logic bclk_ff; // bclk delayed
   logic full_ff; // period valid
   logic [15:0] per_ff; // clocks since rise
   logic [9:0] n_div; // clamped divide factor
   logic [15:0] per_exp; // expected period
   logic wr_ok; // write completes
   assign wr_ok = psel && penable && pready && pwrite;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // mirror software settings
   always_ff @(posedge clk) begin
      if (rst) begin
         ctl_ff <= ASP_CTL_RST;
         psc_ff <= ASP_PSC_RST;
      end else if (wr_ok && paddr == ASP_OFS_CTRL) begin
         ctl_ff <= pwdata & ASP_CTL_MASK;
      end else if (wr_ok && paddr == ASP_OFS_PSC) begin
         psc_ff <= pwdata & ASP_PSC_MASK;
      end
   end
   // time bit periods; writes restart it
   always_ff @(posedge clk) begin
      bclk_ff <= bclk_out;
      if (rst || !bclk_oe || wr_ok) begin
         full_ff <= 1'b0;
         per_ff <= 16'h0000;
      end else if (bclk_out && !bclk_ff) begin
         full_ff <= 1'b1;
         per_ff <= 16'h0001;
      end else begin
         per_ff <= per_ff + 16'h0001;
      end
   end
   // expected period
   always_comb begin
      n_div = {1'b0, psc_ff[7:0], 1'b0} + {9'h000, psc_ff[ASP_PSC_ODD]};
      if (n_div < 10'h002) begin
         n_div = 10'h002;
      end
      per_exp = {6'h00, n_div};
      if (psc_ff[ASP_PSC_MCKEN]) begin
         per_exp = (ctl_ff[7] || ctl_ff[6:5] != 2'b00) ? per_exp << 2 : per_exp << 3;
      end
   end
   pready_pulse_a: assert property (pready |=> !pready)
      else $error("pready too long");
   pready_wait_a: assert property (psel && !penable ##1 psel && penable |=> pready)
      else $error("pready late");
   err_ready_a: assert property (pslverr |-> pready && paddr > ASP_OFS_STAT)
      else $error("stray pslverr");
   edge_align_a: assert property (
      (ws_oe && $stable(ws_oe) && $changed(ws_out)) || (sd_oe && $stable(sd_oe) && $changed(sd_out))
      |-> $changed(bclk_out) && bclk_out == ((ctl_ff[2:1] == ASP_FMT_PCM) ^ ctl_ff[ASP_CTL_POL]))
      else $error("data on wrong edge");
   oe_pair_a: assert property (ws_oe == bclk_oe)
      else $error("ws and bclk dirs differ");
   pin_dir_a: assert property ($stable(ctl_ff) |-> (!bclk_oe || ctl_ff[0] && !ctl_ff[4])
      && (!sd_oe || ctl_ff[0] && !ctl_ff[3]))
      else $error("pin driven wrongly");
   mclk_rel_a: assert property ($stable(psc_ff) && mclk_oe |-> bclk_oe && psc_ff[ASP_PSC_MCKEN])
      else $error("mclk driven unused");
   bit_period_a: assert property (bclk_out && !bclk_ff && full_ff |-> per_ff == per_exp)
      else $error("bit clock period wrong");
endmodule : asp_core_asserts
bind asp_core asp_core_asserts i_asp_core_asserts (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
   .pready, .pslverr, .bclk_out, .bclk_oe, .ws_out, .ws_oe, .sd_out, .sd_oe, .mclk_oe);

// ---- sim/asp_codec_model.sv ----
// codec model: records sent bits
`timescale 1ns/1ns
module asp_codec_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic pol,
   input wire logic bclk,
   input wire logic sd,
   output logic bclk_in,
   output logic ws_in,
   output logic sd_in,
   output logic [63:0] sh
);
   logic bclk_ff; // bit clock level one cycle ago
   // no frames offered: bclk_in and ws_in idle
   assign bclk_in = pol;
   assign ws_in = 1'b0;
   // toggles so stale data shows
   always_ff @(posedge clk) begin
      if (rst) begin
         sd_in <= 1'b0;
      end else begin
         sd_in <= !sd_in;
      end
   end
   // sample on edge leaving idle
   always_ff @(posedge clk) begin
      bclk_ff <= bclk;
      if (bclk != bclk_ff && bclk != pol) begin
         sh <= {sh[62:0], sd};
      end
   end
endmodule : asp_codec_model

// ---- sim/asp_core_tb.sv ----
// self-checking bench for the audio serial framing block
`timescale 1ns/1ns
module asp_core_tb;
   import asp_pkg::*;
   logic clk, pready, pslverr, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pol = 1'b0;
   logic [ASP_AW-1:0] paddr = '0;
   logic [31:0] prdata, pwdata = '0;
   logic [31:0] q; // last read data
   logic e; // last slave error
   logic bclk_in, bclk_out, bclk_oe, ws_in, ws_out, ws_oe, sd_in, sd_out, sd_oe, mclk_out, mclk_oe;
   logic [63:0] sh; // bits seen by the codec
   int n_mismatch = 0;
   int tests_run = 0;
   asp_core i_asp_core (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .bclk_in, .bclk_out, .bclk_oe, .ws_in, .ws_out, .ws_oe, .sd_in, .sd_out, .sd_oe, .mclk_out, .mclk_oe);
   asp_codec_model i_asp_codec_model (.clk, .rst, .pol, .bclk(bclk_out), .sd(sd_out), .bclk_in, .ws_in,
      .sd_in, .sh);
   // 20 MHz system clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task summarize();
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : summarize
   task chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // wait ran out
   task hang();
      n_mismatch++;
      summarize();
   endtask : hang
   // one apb transfer; answer taken at the edge showing pready
   task apb(input logic w, input logic [ASP_AW-1:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (pready !== 1'b1 && i < 50);
      if (i >= 50) hang();
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // wait for a free slot, full writes are dropped
   task wr_dat(input logic [15:0] d);
      int i;
      i = 0;
      do begin
         apb(1'b0, ASP_OFS_STAT, '0);
         i++;
      end while (q[ASP_ST_TXE] !== 1'b1 && i < 200);
      if (i >= 200) hang();
      apb(1'b1, ASP_OFS_DATA, {16'h0000, d});
   endtask : wr_dat
   // wait for ws (b=0) or bclk (b=1) to be v
   task wt(input bit b, input logic v, output int n);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while ((b ? bclk_out : ws_out) !== v && n < 3000);
      if (n >= 3000) hang();
   endtask : wt
   task rst_dut();
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
   endtask : rst_dut
   function logic [31:0] cfg(input logic [1:0] f, m, sw, input logic sl, po, ls);
      return {22'h00_0000, ls, po, sl, sw, m, f, 1'b1};
   endfunction : cfg
   task t_regs();
      apb(1'b0, ASP_OFS_CTRL, '0);
      chk("ctrl reset", q, ASP_CTL_RST);
      apb(1'b0, ASP_OFS_PSC, '0);
      chk("psc reset", q, ASP_PSC_RST);
      apb(1'b1, ASP_OFS_PSC, 32'hFFFF_FFFF);
      apb(1'b0, ASP_OFS_PSC, '0);
      chk("psc fields", q, ASP_PSC_MASK);
      apb(1'b1, 12'h010, 32'hFFFF_FFFF);
      chk("err write", e, 1'b1);
      apb(1'b0, 12'h010, '0);
      chk("err read", {e, q}, {1'b1, 32'h0000_0000});
   endtask : t_regs
   // master tx of one frame, wire bits checked after it
   task t_frame(input logic [1:0] f, sw, input logic sl, po, input int n, input logic [63:0] w,
      input logic [63:0] exp);
      int k;
      pol <= po;
      rst_dut();
      apb(1'b1, ASP_OFS_PSC, 32'h0000_0001);
      apb(1'b1, ASP_OFS_CTRL, cfg(f, ASP_MODE_MTX, sw, sl, po, 1'b0));
      for (int i = 0; i < n; i++) wr_dat(w[63-16*i -: 16]);
      for (int i = 0; i < n / 2; i++) wr_dat(16'h0000);
      wt(1'b0, 1'b1, k);
      wt(1'b0, 1'b0, k);
      chk("frame", sl ? sh : {32'h0000_0000, sh[31:0]}, exp);
   endtask : t_frame
   // pcm sync width in clocks, two per bit
   task t_pcm(input logic ls, input int exp);
      int k;
      pol <= 1'b0;
      rst_dut();
      apb(1'b1, ASP_OFS_PSC, 32'h0000_0001);
      apb(1'b1, ASP_OFS_CTRL, cfg(ASP_FMT_PCM, ASP_MODE_MTX, ASP_WID_16, 1'b0, 1'b0, ls));
      wr_dat(16'h8001);
      wr_dat(16'h4002);
      wt(1'b0, 1'b0, k);
      wt(1'b0, 1'b1, k);
      wt(1'b0, 1'b0, k);
      chk("sync", 64'(k), 64'(exp));
   endtask : t_pcm
   // time one bit period in master rx
   task t_clk(input logic [31:0] ps, input logic sl, input int exp);
      int a;
      int b;
      rst_dut();
      apb(1'b1, ASP_OFS_PSC, ps);
      apb(1'b1, ASP_OFS_CTRL, cfg(ASP_FMT_MSB, ASP_MODE_MRX, ASP_WID_16, sl, 1'b0, 1'b0));
      wt(1'b1, 1'b0, a);
      wt(1'b1, 1'b1, a);
      wt(1'b1, 1'b0, a);
      wt(1'b1, 1'b1, b);
      chk("period", 64'(a + b), 64'(exp));
      chk("rx dirs", {mclk_oe, sd_oe}, {ps[ASP_PSC_MCKEN], 1'b0});
   endtask : t_clk
   task t_modes();
      logic [1:0] m;
      for (int i = 0; i < 4; i++) begin
         m = 2'(i);
         rst_dut();
         apb(1'b1, ASP_OFS_PSC, 32'h0000_0202);
         apb(1'b1, ASP_OFS_CTRL, cfg(ASP_FMT_MSB, m, ASP_WID_16, 1'b0, 1'b0, 1'b0));
         repeat (3) @(negedge clk);
         chk("dirs", {bclk_oe, ws_oe, sd_oe, mclk_oe}, {~m[1], ~m[1], ~m[0], ~m[1]});
      end
   endtask : t_modes
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_frame(ASP_FMT_MSB, ASP_WID_16, 1'b0, 1'b0, 2, 64'hA5C3_3C5A_0000_0000, 64'h0000_0000_A5C3_3C5A);
      t_frame(ASP_FMT_LSB, ASP_WID_16, 1'b0, 1'b1, 2, 64'hA5C3_3C5A_0000_0000, 64'h0000_0000_A5C3_3C5A);
      t_frame(ASP_FMT_LSB, ASP_WID_24, 1'b1, 1'b0, 4, 64'hFF9A_BCDE_7712_3456, 64'h009A_BCDE_0012_3456);
      t_frame(ASP_FMT_MSB, ASP_WID_24, 1'b1, 1'b1, 4, 64'h9ABC_DEFF_1234_5677, 64'h9ABC_DE00_1234_5600);
      t_frame(ASP_FMT_LSB, ASP_WID_16, 1'b1, 1'b0, 2, 64'hA5C3_3C5A_0000_0000, 64'h0000_A5C3_0000_3C5A);
      t_frame(ASP_FMT_MSB, ASP_WID_16, 1'b1, 1'b0, 2, 64'hA5C3_3C5A_0000_0000, 64'hA5C3_0000_3C5A_0000);
      t_pcm(1'b0, 2);
      t_pcm(1'b1, 26);
      t_clk(32'h0000_0102, 1'b0, 5);
      t_clk(32'h0000_0302, 1'b0, 40);
      t_clk(32'h0000_0302, 1'b1, 20);
      t_modes();
      summarize();
   end
endmodule : asp_core_tb
